// file: ccs_pkg.sv
// Package for the complement and compare-skip execution block.
// Assumes a single instruction clock shared with fetch and data memory.
package ccs_pkg;

  // Opcode match patterns on the upper instruction bits.
  localparam logic [5:0] COMP_OPCODE   = 6'h07;
  localparam logic [6:0] CMPEQ_OPCODE  = 7'h31;
  // Field positions in the instruction word.
  localparam int         DEST_BIT      = 9;
  localparam int         ACCESS_BIT    = 8;
  // Highest address handled as indexed literal offset.
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  // Reset values.
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic [3:0] BANK_RESET    = 4'h0;
  localparam logic [7:0] FILE_RESET    = 8'h00;
  // Upper address nibble used for the fixed access bank above the indexed window.
  localparam logic [3:0] ACCESS_HIGH   = 4'hF;
  localparam int         ACCESS_SPLIT  = 8'h60;

  typedef enum logic [2:0] {
    CCS_EXEC  = 3'b001,
    CCS_FLUSH = 3'b010,
    CCS_FLUSH2 = 3'b100
  } ccs_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        twoWord;
  } ccs_instr_t;

  typedef struct packed {
    logic        indexed;
    logic [11:0] addr;
  } ccs_addr_t;

endpackage : ccs_pkg

// file: ccs_regfile.sv
// Small data memory of 4096 bytes with one write port and one registered read.
// Assumes read address is presented a cycle before the data is used.
`timescale 1ns/100ps
module ccs_regfile (
  // Clock.
  input  wire logic        clk,
  // Write port.
  input  wire logic        wrEn,
  input  wire logic [11:0] wrAddr,
  input  wire logic [7:0]  wrData,
  // Read port.
  input  wire logic [11:0] rdAddr,
  output logic [7:0]       rdData
);
  // Cells start cleared so a read before any write is defined.
  logic [7:0] mem [0:4095] = '{default: ccs_pkg::FILE_RESET};

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : ccs_regfile

// file: ccs_exec.sv
// Execution block for complement-register and compare-equal-skip instructions.
// Assumes fetch presents each word with a valid strobe and flags two-word instructions.
// Data memory is internal and read through a register, so each word is held a cycle before its strobe.
// Operation
// - complement instruction inverts the addressed register to form the result.
// - destination bit 0 writes accumulator, 1 writes back to the register.
// - access bit 0 uses fixed access bank, 1 uses bank select register.
// - access 0, extended set on, address at most 95 gives indexed literal offset.
// - compare instruction subtracts accumulator from register unsigned, storing nothing.
// - on equality the already fetched next instruction is discarded.
// - compare takes one cycle without skip, two with skip of a one-word instruction, three with skip of a two-word one.
`timescale 1ns/100ps
module ccs_exec (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset,
  // Configuration.
  input  wire logic              extendedEnable,
  input  wire logic [3:0]        bankSelectRegister,
  input  wire logic [11:0]       indexBase,
  // Instruction stream; each word is held for two cycles (read, then execute).
  input  wire ccs_pkg::ccs_instr_t instrIn,
  input  wire logic              execStrobe,
  // Status outputs.
  output logic [7:0]             workingAccumulator,
  output logic                   skipActive,
  output logic                   instrDone,
  output logic [7:0]             lastResult
);
  ccs_pkg::ccs_state_t stateQ;
  ccs_pkg::ccs_state_t stateD;
  logic [7:0]          accQ;
  logic [7:0]          accD;
  logic [7:0]          resultQ;
  logic [7:0]          resultD;
  logic                doneQ;
  logic                doneD;

  // Operand read back from data memory one cycle after its address.
  logic [7:0]          fileData;

  // Opcode and operand fields.
  logic [5:0]          upperSix;
  logic [6:0]          upperSeven;
  logic                isComp;
  logic                isCmpEq;
  logic                destFile;
  logic                accessBank;
  logic [7:0]          fAddr;

  // Address paths.
  logic                belowLimit;
  logic                aboveSplit;
  logic                indexedHit;
  logic [11:0]         indexedAddr;
  logic [3:0]          accessUpper;
  logic [11:0]         accessAddr;
  logic [11:0]         bankedAddr;
  logic [11:0]         effAddr;
  ccs_pkg::ccs_addr_t  eff;

  // Data path.
  logic [7:0]          complement;
  logic [8:0]          difference;
  logic                equal;

  // Sequencer qualifiers.
  logic                inExec;
  logic                wordHere;
  logic                live;
  logic                compTaken;
  logic                skipStart;
  logic                pairHere;
  logic                flushStep;
  logic                skipEnd;
  logic                wrEn;
  logic                accWrEn;

  // Operand fields of the held word.
  assign upperSix   = instrIn.word[15:10];
  assign upperSeven = instrIn.word[15:9];
  assign destFile   = instrIn.word[ccs_pkg::DEST_BIT];
  assign accessBank = ~instrIn.word[ccs_pkg::ACCESS_BIT];
  assign fAddr      = instrIn.word[7:0];

  assign isComp  = upperSix == ccs_pkg::COMP_OPCODE;
  assign isCmpEq = upperSeven == ccs_pkg::CMPEQ_OPCODE;

  assign belowLimit  = fAddr <= ccs_pkg::INDEXED_LIMIT;
  assign indexedHit  = accessBank && extendedEnable && belowLimit;
  assign indexedAddr = 12'(indexBase + {4'h0, fAddr});

  // fixed access bank or banked register.
  assign aboveSplit  = fAddr >= 8'(ccs_pkg::ACCESS_SPLIT);
  assign accessUpper = aboveSplit ? ccs_pkg::ACCESS_HIGH : ccs_pkg::BANK_RESET;
  assign accessAddr  = {accessUpper, fAddr};
  assign bankedAddr  = {bankSelectRegister, fAddr};
  // The read address follows the held word, so the operand is ready by the strobe.
  assign effAddr     = indexedHit ? indexedAddr : (accessBank ? accessAddr : bankedAddr);
  assign eff         = '{indexed: indexedHit, addr: effAddr};

  for (genvar bitIdx = 0; bitIdx < 8; bitIdx++) begin : gComplement
    assign complement[bitIdx] = ~fileData[bitIdx];
  end

  assign difference = {1'b0, fileData} - {1'b0, accQ};
  assign equal      = difference == 9'h000;

  // Only the execute state of the sequencer takes a word.
  assign inExec    = stateQ == ccs_pkg::CCS_EXEC;
  assign wordHere  = execStrobe && instrIn.valid;
  assign live      = inExec && wordHere;
  assign compTaken = live && isComp;
  assign wrEn      = compTaken && destFile;
  assign accWrEn   = compTaken && !destFile;

  ccs_regfile uFile (
    .clk    (clk),
    .wrEn   (wrEn),
    .wrAddr (eff.addr),
    .wrData (complement),
    .rdAddr (eff.addr),
    .rdData (fileData)
  );

  // an equal compare starts the flush of the next word.
  assign skipStart = live && isCmpEq && equal;
  // a two-word instruction keeps the flush for its second word.
  assign pairHere  = instrIn.valid && instrIn.twoWord;
  assign flushStep = !inExec && execStrobe;

  // Next sequencer state.
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ccs_pkg::CCS_EXEC: begin
        if (skipStart) begin
          stateD = ccs_pkg::CCS_FLUSH;
        end
      end
      ccs_pkg::CCS_FLUSH: begin
        if (flushStep && pairHere) begin
          stateD = ccs_pkg::CCS_FLUSH2;
        end else if (flushStep) begin
          stateD = ccs_pkg::CCS_EXEC;
        end
      end
      ccs_pkg::CCS_FLUSH2: begin
        if (flushStep) begin
          stateD = ccs_pkg::CCS_EXEC;
        end
      end
      default: begin
        // An illegal code returns to execute.
        stateD = ccs_pkg::CCS_EXEC;
      end
    endcase
  end

  // completion one cycle after execution or after the last flushed word.
  assign skipEnd = !inExec && (stateD == ccs_pkg::CCS_EXEC);
  assign doneD   = live || skipEnd;
  // Registers hold unless their instruction writes them.
  assign accD    = accWrEn ? complement : accQ;
  assign resultD = compTaken ? complement : resultQ;

  // Sequencer state register.
  always_ff @(posedge clk) begin
    if (reset) begin
      stateQ <= ccs_pkg::CCS_EXEC;
    end else begin
      stateQ <= stateD;
    end
  end

  // Accumulator register.
  always_ff @(posedge clk) begin
    if (reset) begin
      accQ <= ccs_pkg::ACC_RESET;
    end else begin
      accQ <= accD;
    end
  end

  // Last complement result.
  always_ff @(posedge clk) begin
    if (reset) begin
      resultQ <= ccs_pkg::FILE_RESET;
    end else begin
      resultQ <= resultD;
    end
  end

  // Completion pulse.
  always_ff @(posedge clk) begin
    if (reset) begin
      doneQ <= 1'b0;
    end else begin
      doneQ <= doneD;
    end
  end

  // Outputs come straight from registers.
  assign workingAccumulator = accQ;
  assign lastResult         = resultQ;
  assign instrDone          = doneQ;
  // the skip shows as a flush level until the sequencer returns.
  assign skipActive         = !inExec;
endmodule : ccs_exec

// file: ccs_exec_properties.sv
// Port checker for the complement and compare-skip execution block.
// Assumes it is bound to ccs_exec and shares its clock and reset.
`timescale 1ns/100ps
module ccs_chk (
  // Watched ports.
  input wire logic                clk,
  input wire logic                reset,
  input wire ccs_pkg::ccs_instr_t instrIn,
  input wire logic                execStrobe,
  input wire logic [7:0]          workingAccumulator,
  input wire logic                skipActive,
  input wire logic                instrDone,
  input wire logic [7:0]          lastResult
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire taken = execStrobe && instrIn.valid && !skipActive;
  wire flush = execStrobe && instrIn.valid && skipActive;
  wire isComp = instrIn.word[15:10] == ccs_pkg::COMP_OPCODE;
  wire isCmp = instrIn.word[15:9] == ccs_pkg::CMPEQ_OPCODE;
  wire dest = instrIn.word[ccs_pkg::DEST_BIT];
  acc_write_a: assert property (taken && isComp && !dest |=> workingAccumulator == lastResult)
    else $error("complement to accumulator lost");
  acc_keep_a: assert property (taken && isComp && dest |=> $stable(workingAccumulator))
    else $error("write back touched accumulator");
  cmp_nostore_a: assert property (taken && isCmp |=> $stable(workingAccumulator) && $stable(lastResult))
    else $error("compare stored a result");
  done_pulse_a: assert property (taken |=> instrDone)
    else $error("no completion pulse");
  skip_cause_a: assert property ($rose(skipActive) |-> $past(taken && isCmp))
    else $error("skip without compare");
  skip_end_a: assert property (flush && !instrIn.twoWord |=> !skipActive)
    else $error("skip did not end");
  skip_two_a: assert property (flush && instrIn.twoWord |=> skipActive)
    else $error("two word skip ended early");
  flush_drop_a: assert property (flush |=> $stable(workingAccumulator) && $stable(lastResult))
    else $error("flushed word executed");
  cover property (taken && isCmp);
  cover property ($rose(skipActive));
  cover property (flush && instrIn.twoWord);
endmodule : ccs_chk
bind ccs_exec ccs_chk u_chk (
  .clk                (clk),
  .reset              (reset),
  .instrIn            (instrIn),
  .execStrobe         (execStrobe),
  .workingAccumulator (workingAccumulator),
  .skipActive         (skipActive),
  .instrDone          (instrDone),
  .lastResult         (lastResult)
);

// file: tb.sv
// Self-checking bench for the execution block.
// Assumes data memory cells start at the package's cleared value, which seeds the model.
`timescale 1ns/100ps
module tb;
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t mismatch", $time); end end
  logic clk = 0, reset = 1, execStrobe = 0, extendedEnable = 0;
  logic [3:0] bankSelectRegister = 0;
  logic [11:0] indexBase = 0;
  ccs_pkg::ccs_instr_t instrIn = '0;
  logic [7:0] workingAccumulator, lastResult, acc, f;
  logic skipActive, instrDone, a, tw;
  logic [11:0] p;
  int n_mismatch = 0, total_checks = 0;
  logic [7:0] mem [int];
  always #12.5 clk = ~clk;
  ccs_exec u_dut (
    .clk                (clk),
    .reset              (reset),
    .extendedEnable     (extendedEnable),
    .bankSelectRegister (bankSelectRegister),
    .indexBase          (indexBase),
    .instrIn            (instrIn),
    .execStrobe         (execStrobe),
    .workingAccumulator (workingAccumulator),
    .skipActive         (skipActive),
    .instrDone          (instrDone),
    .lastResult         (lastResult)
  );
  function automatic logic [11:0] phys(logic [7:0] fa, logic ab);
    if (ab) return {bankSelectRegister, fa};
    if (extendedEnable && fa <= 8'h5F) return indexBase + 12'(fa);
    return {(fa >= 8'h60) ? 4'hF : 4'h0, fa};
  endfunction : phys
  task op(logic [15:0] w, logic t);
    @(posedge clk) #1 instrIn = '{1'b1, w, t};
    @(posedge clk) #1 execStrobe = 1;
    @(posedge clk) #1 execStrobe = 0;
  endtask : op
  task final_report;
    $display("%0d mismatches in %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial begin
    void'($urandom(32'h4A51));
    repeat (16) @(posedge clk);
    #1 reset = 0;
    for (int i = 0; i < 40; i++) begin
      f = 8'h5E + 8'($urandom % 4);
      a = $urandom;
      tw = $urandom;
      extendedEnable = $urandom;
      bankSelectRegister = ($urandom % 2) ? 4'hF : 4'h0;
      indexBase = ($urandom % 2) ? 12'h002 : 12'hF00;
      p = phys(f, a);
      if (!mem.exists(p)) mem[p] = ccs_pkg::FILE_RESET;
      op({6'h07, 1'b0, a, f}, 1'b0);
      `CHK(workingAccumulator, ~mem[p])
      `CHK(instrDone, 1'b1)
      acc = ~mem[p];
      repeat (1 + $urandom % 3) begin
        op({6'h07, 1'b1, a, f}, 1'b0);
        mem[p] = ~mem[p];
        `CHK(lastResult, mem[p])
        `CHK(workingAccumulator, acc)
        op({7'h31, a, f}, 1'b0);
        `CHK(instrDone, 1'b1)
        `CHK(skipActive, mem[p] == acc)
        if (mem[p] == acc) begin
          op({6'h07, 1'b0, a, f}, tw);
          if (tw) begin
            `CHK(skipActive, 1'b1)
            `CHK(instrDone, 1'b0)
            op({6'h07, 1'b0, a, f}, 1'b0);
          end
          `CHK(skipActive, 1'b0)
          `CHK(instrDone, 1'b1)
          `CHK(workingAccumulator, acc)
        end
      end
    end
    final_report;
  end
endmodule : tb
